// file: hdl/bbr_regs.sv
// Amplifier boost and OTG boost control logic with register bank.
// Assumes a synchronous register port from the SPI slave; pins enter raw.
`timescale 1ns/1ps
`default_nettype none
module bbr_regs
    import bbr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register port
    input wire logic [8:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Pins and analog status
    input wire logic standby_exit_pin,
    input wire logic pa_shutdown_fault,
    input wire logic on_battery,
    input wire logic input_power_present,
    input wire logic usb_detect_raw,
    // OTG controls from the charger control register
    input wire logic host_allow_bit,
    input wire logic isolation_control_bit,
    input wire logic otg_state_on,
    // Outputs
    output logic pa_boost_enable,
    output logic pa_voltage_5v0,
    output logic pa_discharge_enable,
    output logic pa_boost_fault_flag,
    output logic otg_boost_enable,
    output logic otg_isolation_switch,
    output logic otg_host_mode,
    output logic usb_detect_flag
);
    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins and analog status
    localparam int NSYNC = 5;
    // Pins and analog status only; the exit pin edge is found after the second stage
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] async_in;
    assign async_in = {standby_exit_pin, pa_shutdown_fault, on_battery,
                       input_power_present, usb_detect_raw};
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
        end
    end
    logic exit_s;
    logic fault_s;
    logic batt_s;
    logic inpwr_s;
    logic usb_detect_flag_s;
    assign exit_s = sync2_q[4];
    assign fault_s = sync2_q[3];
    assign batt_s = sync2_q[2];
    assign inpwr_s = sync2_q[1];
    assign usb_detect_flag_s = sync2_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] pa_ctrl_q;
    logic [7:0] pa_ctrl_d;
    logic [7:0] pa_dsch_q;
    logic [7:0] pa_dsch_d;
    logic exit_prev_q;
    logic exit_prev_d;
    logic wr_ctrl;
    logic wr_dsch;
    logic exit_rise;
    logic [2:0] new_state;
    logic [2:0] exit_code;
    assign wr_ctrl = reg_wr && (reg_addr == BBR_ADDR_PA_CTRL);
    assign wr_dsch = reg_wr && (reg_addr == BBR_ADDR_PA_DSCH);
    assign exit_rise = exit_s && !exit_prev_q;
    assign new_state = reg_wdata[BBR_STATE_LSB +: 3];
    assign exit_code = pa_ctrl_q[BBR_EXIT_LSB +: 3];

    always_comb begin
        pa_ctrl_d = pa_ctrl_q;
        pa_dsch_d = pa_dsch_q;
        exit_prev_d = exit_s;
        if (wr_ctrl) begin
            pa_ctrl_d = reg_wdata;
        end
        if (wr_dsch) begin
            pa_dsch_d = {7'h00, reg_wdata[0]};
        end
        // Standby exit copies only the two defined codes
        if (exit_rise && (exit_code == BBR_CODE_OFF || exit_code == BBR_CODE_ON)) begin
            pa_ctrl_d[BBR_STATE_LSB +: 3] = exit_code;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pa_ctrl_q <= BBR_PA_CTRL_RST;
            pa_dsch_q <= BBR_PA_DSCH_RST;
            exit_prev_q <= 1'b0;
        end else begin
            pa_ctrl_q <= pa_ctrl_d;
            pa_dsch_q <= pa_dsch_d;
            exit_prev_q <= exit_prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Amplifier boost state machine
    bbr_pa_state_type pa_state_q;
    bbr_pa_state_type pa_state_d;
    logic want_on;
    logic want_off;
    // Commanded transitions come from a software write or a standby exit
    always_comb begin
        want_on = 1'b0;
        want_off = 1'b0;
        if (wr_ctrl) begin
            want_on = (new_state == BBR_CODE_ON);
            want_off = (new_state == BBR_CODE_OFF);
        end
        if (exit_rise) begin
            want_on = want_on || (exit_code == BBR_CODE_ON);
            want_off = want_off || (exit_code == BBR_CODE_OFF);
        end
    end

    always_comb begin
        pa_state_d = pa_state_q; // Other codes hold state
        unique case (pa_state_q)
            BBR_PA_OFF: begin
                if (want_on) begin
                    pa_state_d = BBR_PA_ON;
                end
            end
            BBR_PA_ON: begin
                if (fault_s) begin
                    pa_state_d = BBR_PA_FAULT;
                end else if (want_off) begin
                    pa_state_d = BBR_PA_OFF;
                end
            end
            BBR_PA_FAULT: begin
                // No auto restart; an off command keeps the flag, only an enable leaves
                if (want_on) begin
                    pa_state_d = BBR_PA_ON;
                end
            end
            default: begin
                pa_state_d = BBR_PA_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pa_state_q <= BBR_PA_OFF;
        end else begin
            pa_state_q <= pa_state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // OTG boost, isolation switch and host mode
    logic host_ok;
    logic otg_en_d;
    logic iso_d;
    logic host_d;
    logic usbflag_d;
    logic otg_en_q;
    logic iso_q;
    logic host_q;
    logic usbflag_q;
    always_comb begin
        host_ok = batt_s && !inpwr_s;
        otg_en_d = otg_state_on;
        iso_d = 1'b0;
        if (host_allow_bit && !isolation_control_bit && host_ok) begin
            otg_en_d = 1'b1;
            iso_d = 1'b1;
        end
        host_d = iso_d;
        // Detect flag is masked while hosting the bus
        usbflag_d = usb_detect_flag_s && !host_q;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            otg_en_q <= 1'b0;
            iso_q <= 1'b0;
            host_q <= 1'b0;
            usbflag_q <= 1'b0;
        end else begin
            otg_en_q <= otg_en_d;
            iso_q <= iso_d;
            host_q <= host_d;
            usbflag_q <= usbflag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs and read mux
    assign pa_boost_enable = (pa_state_q == BBR_PA_ON);
    assign pa_boost_fault_flag = (pa_state_q == BBR_PA_FAULT);
    assign pa_voltage_5v0 = (pa_ctrl_q[BBR_VSEL_LSB +: 2] == BBR_VSEL_5V0);
    assign pa_discharge_enable = !pa_dsch_q[0];
    assign otg_boost_enable = otg_en_q;
    assign otg_isolation_switch = iso_q;
    assign otg_host_mode = host_q;
    assign usb_detect_flag = usbflag_q;

    // Unmapped addresses read as zero
    always_comb begin
        if (reg_addr == BBR_ADDR_PA_CTRL) begin
            reg_rdata = pa_ctrl_q;
        end else if (reg_addr == BBR_ADDR_PA_DSCH) begin
            reg_rdata = pa_dsch_q;
        end else begin
            reg_rdata = 8'h00;
        end
    end
endmodule : bbr_regs
`default_nettype wire

// file: hdl/bbr_pkg.sv
// Constants for the boost regulator control register bank.
// Assumes an SPI register port decoded elsewhere into address/strobe form.
// Summary of operation
// - State field bits 2:0 turn the amplifier boost off for code 4 and on for code 7.
// - On the standby-exit pin the state in bits 5:3 is applied, codes other than 4 and 7 leaving it as is.
// - Voltage select bits 7:6 choose 4.2 V for code 0 and 5.0 V for code 2.
// - The amplifier control register at 0x3b is read/write and resets to 0x24.
// - Bit 0 of register 0x1c7 disables the discharge transistor when set; reset 0x01.
// - The isolation switch enable comes from the host-allow and isolation-control bits.
// - Host mode is allowed only on battery with no input power connected.
// - While host mode is on the USB detect flag is ignored.
// - Host-allow 0: switch off, boost by state; 1 with control 0: both on; both 1: switch off.
// - A short or over-voltage shutdown keeps the boost off and flagged until re-enabled.
package bbr_pkg;
    localparam logic [8:0] BBR_ADDR_PA_CTRL = 9'h03b;
    localparam logic [8:0] BBR_ADDR_PA_DSCH = 9'h1c7;
    localparam logic [7:0] BBR_PA_CTRL_RST = 8'h24;
    localparam logic [7:0] BBR_PA_DSCH_RST = 8'h01;
    localparam int BBR_STATE_LSB = 0;
    localparam int BBR_EXIT_LSB = 3;
    localparam int BBR_VSEL_LSB = 6;
    localparam logic [2:0] BBR_CODE_OFF = 3'h4;
    localparam logic [2:0] BBR_CODE_ON = 3'h7;
    localparam logic [1:0] BBR_VSEL_4V2 = 2'h0;
    localparam logic [1:0] BBR_VSEL_5V0 = 2'h2;
    typedef enum logic [1:0] {
        BBR_PA_OFF = 2'b00,
        BBR_PA_ON = 2'b01,
        BBR_PA_FAULT = 2'b10
    } bbr_pa_state_type;
endpackage : bbr_pkg

// file: dv/bbr_regs_sva.sv
// Port checker for the boost regulator register bank.
// Assumes a bind from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module bbr_regs_sva (
    // Clock, reset, register port
    input wire logic sys_clk, nrst, reg_wr,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    // Status and OTG controls
    input wire logic input_power_present, host_allow_bit, isolation_control_bit, otg_state_on,
    // Outputs watched
    input wire logic pa_boost_enable, pa_voltage_5v0, pa_discharge_enable, pa_boost_fault_flag,
    input wire logic otg_boost_enable, otg_isolation_switch, otg_host_mode, usb_detect_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////
    sequence s_ctl_wr; reg_wr && reg_addr == 9'h03b; endsequence
    property p_off; s_ctl_wr ##0 reg_wdata[2:0] == 3'h4 |=> !pa_boost_enable; endproperty
    a_off: assert property (p_off) else $error("off code left boost on");
    property p_back; s_ctl_wr ##1 reg_addr == 9'h03b |-> reg_rdata == $past(reg_wdata);
    endproperty
    a_back: assert property (p_back) else $error("control readback wrong");
    property p_vsel; reg_addr == 9'h03b |-> pa_voltage_5v0 == (reg_rdata[7:6] == 2'h2);
    endproperty
    a_vsel: assert property (p_vsel) else $error("voltage select wrong");
    property p_dsch; reg_addr == 9'h1c7 |-> reg_rdata == {7'h00, !pa_discharge_enable};
    endproperty
    a_dsch: assert property (p_dsch) else $error("discharge bit wrong");
    // Checks a latched fault holds, boost off, in every cycle without a control write
    property p_flt; pa_boost_fault_flag && !(reg_wr && reg_addr == 9'h03b)
        |=> pa_boost_fault_flag && !pa_boost_enable; endproperty
    a_flt: assert property (p_flt) else $error("fault flag dropped");
    property p_otg; !host_allow_bit || isolation_control_bit
        |=> !otg_isolation_switch && otg_boost_enable == $past(otg_state_on); endproperty
    a_otg: assert property (p_otg) else $error("otg truth table wrong");
    property p_ext; input_power_present [*4] |=> !otg_isolation_switch; endproperty
    a_ext: assert property (p_ext) else $error("switch on with input power");
    property p_usb; otg_host_mode |=> !usb_detect_flag; endproperty
    a_usb: assert property (p_usb) else $error("detect flag in host mode");
endmodule : bbr_regs_sva
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the boost regulator register bank.
// Assumes bbr_pkg and bbr_regs are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk = 0, nrst = 0, reg_wr = 0, standby_exit_pin = 0, pa_shutdown_fault = 0;
    logic on_battery = 1, input_power_present = 0, usb_detect_raw = 0, host_allow_bit = 0;
    logic isolation_control_bit = 0, otg_state_on = 0;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic pa_boost_enable, pa_voltage_5v0, pa_discharge_enable, pa_boost_fault_flag;
    logic otg_boost_enable, otg_isolation_switch, otg_host_mode, usb_detect_flag;
    logic [7:0] wd [8] = '{8'h27, 8'h20, 8'h61, 8'ha5, 8'he6, 8'ha4, 8'h23, 8'h27};
    logic [0:7] en = 8'hf9;
    int fail_count = 0, n_compared = 0;
    bbr_regs dut (.*);
    initial forever #12.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic chk(input string s, input logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        cyc(1);
        reg_wr = 0;
        cyc(1);
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        reg_addr = a;
        cyc(1);
        chk("rdata", e, reg_rdata);
    endtask : rd
    task automatic close_out;
        $display("Compared %0d, errors %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    // Whole run is about 114 cycles
    initial begin
        #100us;
        fail_count++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(12);
        nrst = 1;
        rd(9'h03b, 8'h24);
        rd(9'h1c7, 8'h01);
        chk("en", 0, pa_boost_enable);
        foreach (wd[i]) begin
            wr(9'h03b, wd[i]);
            chk("en", en[i], pa_boost_enable);
            chk("v5", wd[i][7:6] == 2'h2, pa_voltage_5v0);
            rd(9'h03b, wd[i]);
        end
        wr(9'h1c7, 8'hff);
        rd(9'h1c7, 8'h01);
        chk("dsch", 0, pa_discharge_enable);
        wr(9'h1c7, 8'hfe);
        chk("dsch", 1, pa_discharge_enable);
        // Bit 8 differs only: catches a truncated decode
        wr(9'h13b, 8'hff);
        rd(9'h13b, 8'h00);
        rd(9'h03b, 8'h27);
        for (int i = 0; i < 3; i++) begin
            wr(9'h03b, i == 0 ? 8'h27 : i == 1 ? 8'h1f : 8'h3c);
            standby_exit_pin = 1;
            cyc(4);
            standby_exit_pin = 0;
            chk("exit", i != 0, pa_boost_enable);
        end
        pa_shutdown_fault = 1;
        cyc(1);
        pa_shutdown_fault = 0;
        cyc(8);
        chk("flt", 1, pa_boost_fault_flag);
        chk("en", 0, pa_boost_enable);
        wr(9'h03b, 8'h24);
        chk("flt", 1, pa_boost_fault_flag);
        wr(9'h03b, 8'h27);
        chk("flt", 0, pa_boost_fault_flag);
        // Isolation switch taken as fitted, so OTG discharge may stay enabled
        for (int i = 0; i < 8; i++) begin
            {host_allow_bit, isolation_control_bit, otg_state_on} = i[2:0];
            cyc(2);
            chk("boost", otg_state_on | (host_allow_bit & !isolation_control_bit),
                otg_boost_enable);
            chk("sw", host_allow_bit & !isolation_control_bit, otg_isolation_switch);
            chk("host", host_allow_bit & !isolation_control_bit, otg_host_mode);
        end
        {host_allow_bit, isolation_control_bit} = 2'h2;
        for (int i = 0; i < 3; i++) begin
            {on_battery, input_power_present} = i == 0 ? 2'h3 : i == 1 ? 2'h0 : 2'h2;
            cyc(4);
            chk("sw", i == 2, otg_isolation_switch);
        end
        usb_detect_raw = 1;
        cyc(4);
        chk("usb", 0, usb_detect_flag);
        host_allow_bit = 0;
        cyc(4);
        chk("usb", 1, usb_detect_flag);
        close_out();
    end
endmodule : testbench
bind bbr_regs bbr_regs_sva chk (.*);
`default_nettype wire
